/* File: design/chgsf_pkg.sv */
/*
 * Package for the charger status and fault register bank: register
 * addresses, field positions, reset values, bus address and carriers.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package chgsf_pkg;

  // Register addresses on the serial bus, and the byte read back from unmapped ones
  localparam logic [7:0] CHGSF_ADDR_STATUS = 8'h00;
  localparam logic [7:0] CHGSF_ADDR_FAULT = 8'h01;
  localparam logic [7:0] CHGSF_ADDR_TSCTL = 8'h02;
  localparam logic [7:0] CHGSF_UNMAPPED_DATA = 8'hFF;

  // Seven-bit slave address
  localparam logic [6:0] CHGSF_SLAVE_ADDR = 7'h6A;

  // Status register field positions
  localparam int CHGSF_ST_STATE_HI = 7;
  localparam int CHGSF_ST_STATE_LO = 6;
  localparam int CHGSF_ST_SHIP = 5;
  localparam int CHGSF_ST_RESET = 4;
  localparam int CHGSF_ST_TIMER = 3;
  localparam int CHGSF_ST_DPM = 2;
  localparam int CHGSF_ST_CD = 1;
  localparam int CHGSF_ST_SYS = 0;

  // Fault register field positions
  localparam int CHGSF_FL_INPUT_OVERVOLTAGE_FLAG = 7;
  localparam int CHGSF_FL_INPUT_UNDERVOLTAGE_FLAG = 6;
  localparam int CHGSF_FL_BAT_UV = 5;
  localparam int CHGSF_FL_BAT_OC = 4;

  // Temperature-sense control field positions
  localparam int CHGSF_TS_EN = 7;
  localparam int CHGSF_TS_FAULT_HI = 6;
  localparam int CHGSF_TS_FAULT_LO = 5;

  // Reset values of the writable fields
  localparam logic [3:0] CHGSF_FAULT_MASK_RST = 4'h0;
  localparam logic CHGSF_TS_EN_RST = 1'b1;
  localparam logic [3:0] CHGSF_TS_LOW_RST = 4'h8;

  // Live conditions from the charger core
  typedef struct packed {
    logic [1:0] charge_state;
    logic reset_condition;
    logic timer_expired;
    logic input_dpm_active;
    logic system_switch_state;
    logic input_overvoltage;
    logic input_undervoltage;
    logic battery_undervoltage;
    logic battery_overcurrent;
    logic [1:0] ts_fault;
  } chgsf_cond_t;

  // Byte-level port between the serial engine and the register file
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } chgsf_req_t;

  typedef enum logic [1:0] {CHGSF_OP_NONE, CHGSF_OP_WR, CHGSF_OP_RD}
    chgsf_op_t;

endpackage

/* File: design/chgsf_i2c_slave.sv */
/*
 * Two-wire serial slave engine. Turns bus frames into one-cycle register
 * write and read requests and shifts read data out.
 * Assumes scl and sda inputs already pass two flip-flops in the caller,
 * and that the caller returns read data in the cycle after a read pulse.
 */
`timescale 1ns/10ps
module chgsf_i2c_slave
  import chgsf_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic scl_s,
  input wire logic sda_s,
  input wire logic [7:0] rd_data,
  output chgsf_req_t req,
  output logic sda_oe
);

  typedef enum {CHGSF_IDLE, CHGSF_ADR, CHGSF_AACK, CHGSF_REG, CHGSF_RACK,
    CHGSF_WDAT, CHGSF_WACK, CHGSF_RDAT, CHGSF_MACK} chgsf_st_t;

  chgsf_st_t st_q, st_d;
  logic scl_q, sda_q;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] ptr_q, ptr_d;
  logic rnw_q, rnw_d;
  logic oe_q, oe_d;
  chgsf_req_t req_q, req_d;

  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_c = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_c = scl_s & scl_q & ~sda_q & sda_s;
  assign req = req_q;
  assign sda_oe = oe_q;

  // Frame decode; bits are sampled on the rising edge, driven on falling
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    rnw_d = rnw_q;
    oe_d = oe_q;
    req_d = '0;
    if (start_c) begin
      st_d = CHGSF_ADR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else if (stop_c) begin
      st_d = CHGSF_IDLE;
      oe_d = 1'b0;
    end else begin
      case (st_q)
        CHGSF_ADR, CHGSF_REG, CHGSF_WDAT: begin
          if (scl_rise) begin
            sh_d = {sh_q[6:0], sda_s};
            cnt_d = cnt_q + 4'h1;
          end
          if (scl_fall && cnt_q == 4'h8) begin
            cnt_d = 4'h0;
            if (st_q == CHGSF_ADR) begin
              // Only our own address is acknowledged
              if (sh_q[7:1] == CHGSF_SLAVE_ADDR) begin
                rnw_d = sh_q[0];
                oe_d = 1'b1;
                st_d = CHGSF_AACK;
              end else begin
                st_d = CHGSF_IDLE;
              end
            end else if (st_q == CHGSF_REG) begin
              ptr_d = sh_q;
              oe_d = 1'b1;
              st_d = CHGSF_RACK;
            end else begin
              req_d.wr = 1'b1;
              req_d.addr = ptr_q;
              req_d.data = sh_q;
              oe_d = 1'b1;
              st_d = CHGSF_WACK;
            end
          end
        end
        CHGSF_AACK, CHGSF_RACK, CHGSF_WACK: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            if (st_q == CHGSF_AACK && rnw_q) begin
              req_d.rd = 1'b1;
              req_d.addr = ptr_q;
              st_d = CHGSF_RDAT;
              cnt_d = 4'hE;
            end else begin
              if (st_q == CHGSF_WACK) ptr_d = ptr_q + 8'h01;
              st_d = (st_q == CHGSF_AACK) ? CHGSF_REG : CHGSF_WDAT;
            end
          end
        end
        CHGSF_RDAT: begin
          // Wait out the pulse cycle; the register file latches at its end
          if (cnt_q == 4'hE) begin
            cnt_d = 4'hF;
          end else if (cnt_q == 4'hF) begin
            sh_d = rd_data;
            oe_d = ~rd_data[7];
            cnt_d = 4'h0;
          end else if (scl_fall) begin
            if (cnt_q == 4'h7) begin
              oe_d = 1'b0;
              st_d = CHGSF_MACK;
            end else begin
              sh_d = {sh_q[6:0], 1'b1};
              oe_d = ~sh_q[6];
            end
            cnt_d = cnt_q + 4'h1;
          end
        end
        CHGSF_MACK: begin
          if (scl_rise) rnw_d = ~sda_s;
          if (scl_fall) begin
            if (rnw_q) begin
              ptr_d = ptr_q + 8'h01;
              req_d.rd = 1'b1;
              req_d.addr = ptr_q + 8'h01;
              st_d = CHGSF_RDAT;
              cnt_d = 4'hE;
            end else begin
              st_d = CHGSF_IDLE;
            end
          end
        end
        default: st_d = CHGSF_IDLE;
      endcase
    end
  end

  // State registers
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_q <= CHGSF_IDLE;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      rnw_q <= 1'b0;
      oe_q <= 1'b0;
      req_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
      scl_q <= scl_s;
      sda_q <= sda_s;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      rnw_q <= rnw_d;
      oe_q <= oe_d;
      req_q <= req_d;
    end
  end

endmodule

/* File: design/chgsf_regs.sv */
/*
 * Charger status and fault register bank behind a two-wire serial slave.
 * Assumes the charger core supplies live conditions on mclk, and that the
 * bus pins arrive asynchronously; the board resolves sda from sda_oe.
 */
`timescale 1ns/10ps
module chgsf_regs
  import chgsf_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic chip_disable_pin,
  input chgsf_cond_t cond,
  output logic sda_out,
  output logic sda_oe,
  output logic ship_mode_request,
  output logic ts_enable,
  output logic [3:0] fault_mask,
  output logic [3:0] ts_low_ctl
);

  // Two-stage synchronisers for the pins
  logic scl_m_q, scl_s_q, sda_m_q, sda_s_q, cd_m_q, cd_s_q, cd_prev_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      cd_m_q <= 1'b0;
      cd_s_q <= 1'b0;
      cd_prev_q <= 1'b0;
    end else if (ce) begin
      scl_m_q <= scl_in;
      scl_s_q <= scl_m_q;
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
      cd_m_q <= chip_disable_pin;
      cd_s_q <= cd_m_q;
      cd_prev_q <= cd_s_q;
    end
  end

  chgsf_req_t req;
  logic oe_w;
  logic [7:0] rd_q, rd_d;

  chgsf_i2c_slave chgsf_i2c_slave_inst (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .scl_s(scl_s_q),
    .sda_s(sda_s_q),
    .rd_data(rd_q),
    .req(req),
    .sda_oe(oe_w)
  );

  // Address decode shared by the read and write paths
  function automatic chgsf_op_t hit(input chgsf_req_t r,
                                    input logic [7:0] a);
    if (r.wr && r.addr == a) return CHGSF_OP_WR;
    else if (r.rd && r.addr == a) return CHGSF_OP_RD;
    else return CHGSF_OP_NONE;
  endfunction

  // Register state
  logic ship_q, ship_d;
  logic rst_flag_q, rst_flag_d;
  logic timer_q, timer_d;
  logic uv_q, uv_d, uv_prev_q;
  logic oc_q, oc_d, oc_prev_q;
  logic [3:0] mask_q, mask_d;
  logic ts_en_q, ts_en_d;
  logic [3:0] ts_low_q, ts_low_d;
  logic cd_toggle;
  chgsf_op_t op_st, op_fl, op_ts;

  assign cd_toggle = cd_s_q ^ cd_prev_q;

  // Next-state logic; a hardware set always wins over a read clear
  always_comb begin
    op_st = hit(req, CHGSF_ADDR_STATUS);
    op_fl = hit(req, CHGSF_ADDR_FAULT);
    op_ts = hit(req, CHGSF_ADDR_TSCTL);
    ship_d = ship_q;
    mask_d = mask_q;
    ts_en_d = ts_en_q;
    ts_low_d = ts_low_q;
    // Only the writable fields take bus data
    if (op_st == CHGSF_OP_WR) begin
      ship_d = req.data[CHGSF_ST_SHIP];
    end
    if (op_fl == CHGSF_OP_WR) begin
      mask_d = req.data[3:0];
    end
    if (op_ts == CHGSF_OP_WR) begin
      ts_en_d = req.data[CHGSF_TS_EN];
      ts_low_d = req.data[3:0];
    end
    // Reset flag: read clears, criteria set
    rst_flag_d = rst_flag_q;
    if (op_st == CHGSF_OP_RD) rst_flag_d = 1'b0;
    if (cond.reset_condition) rst_flag_d = 1'b1;
    // Timer fault survives reads
    timer_d = timer_q;
    if (cd_toggle) timer_d = 1'b0;
    if (cond.timer_expired) timer_d = 1'b1;
    // Undervoltage shows once per rising event
    uv_d = uv_q;
    if (op_fl == CHGSF_OP_RD) uv_d = 1'b0;
    if (cond.input_undervoltage && !uv_prev_q) uv_d = 1'b1;
    // Overcurrent: set on event, cleared by fault read
    oc_d = oc_q;
    if (op_fl == CHGSF_OP_RD) oc_d = 1'b0;
    if (cond.battery_overcurrent && !oc_prev_q) oc_d = 1'b1;
  end

  // Read data mux, sampled one cycle after the read pulse
  always_comb begin
    rd_d = rd_q;
    if (req.rd) begin
      case (req.addr)
        CHGSF_ADDR_STATUS: begin
          rd_d = 8'h00;
          rd_d[7:6] = cond.charge_state;
          rd_d[CHGSF_ST_SHIP] = 1'b0; // Write-only bit reads 0
          rd_d[CHGSF_ST_RESET] = rst_flag_q;
          rd_d[CHGSF_ST_TIMER] = timer_q;
          rd_d[CHGSF_ST_DPM] = cond.input_dpm_active;
          rd_d[CHGSF_ST_CD] = cd_s_q;
          rd_d[CHGSF_ST_SYS] = cond.system_switch_state;
        end
        CHGSF_ADDR_FAULT: begin
          rd_d[CHGSF_FL_INPUT_OVERVOLTAGE_FLAG] = cond.input_overvoltage;
          rd_d[CHGSF_FL_INPUT_UNDERVOLTAGE_FLAG] = uv_q;
          rd_d[CHGSF_FL_BAT_UV] = cond.battery_undervoltage;
          rd_d[CHGSF_FL_BAT_OC] = oc_q;
          rd_d[3:0] = mask_q;
        end
        CHGSF_ADDR_TSCTL: begin
          rd_d = {ts_en_q, cond.ts_fault, 1'b0, ts_low_q};
        end
        default: rd_d = CHGSF_UNMAPPED_DATA;
      endcase
    end
  end

  // Register file flops; reserved bit 4 of the sensing register reads 0
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ship_q <= 1'b0;
      rst_flag_q <= 1'b0;
      timer_q <= 1'b0;
      uv_q <= 1'b0;
      uv_prev_q <= 1'b0;
      oc_q <= 1'b0;
      oc_prev_q <= 1'b0;
      mask_q <= CHGSF_FAULT_MASK_RST;
      ts_en_q <= CHGSF_TS_EN_RST;
      ts_low_q <= CHGSF_TS_LOW_RST;
      rd_q <= 8'h00;
    end else if (ce) begin
      ship_q <= ship_d;
      rst_flag_q <= rst_flag_d;
      timer_q <= timer_d;
      uv_q <= uv_d;
      uv_prev_q <= cond.input_undervoltage;
      oc_q <= oc_d;
      oc_prev_q <= cond.battery_overcurrent;
      mask_q <= mask_d;
      ts_en_q <= ts_en_d;
      ts_low_q <= ts_low_d;
      rd_q <= rd_d;
    end
  end

  // Open-drain: data out is constant low, enable comes from a flop
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
    end else if (ce) begin
      sda_out <= 1'b0;
      sda_oe <= oe_w;
    end
  end

  assign ship_mode_request = ship_q;
  assign ts_enable = ts_en_q;
  assign fault_mask = mask_q;
  assign ts_low_ctl = ts_low_q;

endmodule

/* File: testbench/chgsf_monitor.sv */
/* Port checker for the charger status and fault register bank.
   Assumes one clock mclk, async reset rstn, bound to chgsf_regs below. */
`timescale 1ns/10ps
module chgsf_monitor
  import chgsf_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic chip_disable_pin,
  input chgsf_cond_t cond,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic ship_mode_request,
  input wire logic ts_enable,
  input wire logic [3:0] fault_mask,
  input wire logic [3:0] ts_low_ctl
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  // A stored byte is answered by the slave acknowledge shortly after
  sequence ack_s;
    ##[0:8] sda_oe;
  endsequence

  reset_vals_a: assert property ($rose(rstn) |->
    !ship_mode_request && ts_enable && fault_mask == 4'h0
    && ts_low_ctl == 4'h8) else $error("outputs not at reset values");
  sda_low_a: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  ack_scl_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data moved while clock high");
  mask_scl_a: assert property ($changed(fault_mask) |-> !scl_in)
    else $error("mask moved outside a byte end");
  ship_scl_a: assert property ($changed(ship_mode_request) |->
    !scl_in) else $error("ship request moved outside a byte end");
  ts_scl_a: assert property ($changed({ts_enable, ts_low_ctl}) |->
    !scl_in) else $error("control moved outside a byte end");
  write_ack_a: assert property ($changed({ship_mode_request,
    ts_enable, fault_mask, ts_low_ctl}) |-> ack_s)
    else $error("register update without acknowledge");
  freeze_a: assert property (!ce |=> $stable({sda_oe,
    ship_mode_request, ts_enable, fault_mask, ts_low_ctl}))
    else $error("state moved while clock enable low");
endmodule

bind chgsf_regs chgsf_monitor chgsf_monitor_inst (.mclk(mclk), .rstn(rstn),
  .ce(ce), .scl_in(scl_in), .sda_in(sda_in),
  .chip_disable_pin(chip_disable_pin), .cond(cond), .sda_out(sda_out),
  .sda_oe(sda_oe), .ship_mode_request(ship_mode_request),
  .ts_enable(ts_enable), .fault_mask(fault_mask), .ts_low_ctl(ts_low_ctl));

/* File: testbench/chgsf_host_model.sv */
/* Two-wire bus master model that reaches the register bank.
   Assumes the bench resolves the data wire from both drivers. */
`timescale 1ns/10ps
module chgsf_host_model
  import chgsf_pkg::*;
#(parameter int HALF = 21) // Three halves per bit keep the bus near 400 kHz
(
  input wire logic mclk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_oe
);
  // Both lines released at power-up, pull-ups hold them high
  initial begin
    scl = 1'h1;
    sda_oe = 1'h0;
  end

  task automatic hp();
    repeat (HALF) @(posedge mclk);
    #1;
  endtask

  // Low phase is two half periods so data never moves near a clock edge
  task automatic xbit(input logic b, output logic r);
    sda_oe = !b;
    hp();
    scl = 1'h1;
    hp();
    r = sda_line;
    scl = 1'h0;
    hp();
  endtask

  task automatic xbyte(input logic [7:0] v, input logic last,
                       output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) xbit(v[i], r[i]);
    xbit(last, ack);
  endtask

  task automatic start_c();
    sda_oe = 1'h0;
    hp();
    scl = 1'h1;
    hp();
    sda_oe = 1'h1;
    hp();
    scl = 1'h0;
    hp();
  endtask

  task automatic stop_c();
    sda_oe = 1'h1;
    hp();
    scl = 1'h1;
    hp();
    sda_oe = 1'h0;
    hp();
  endtask

  // Value 1 in the ship bit asks for ship mode, 0 keeps normal work
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a,
                           input logic [7:0] v, output logic nak);
    logic [7:0] r;
    logic k0, k1, k2;
    start_c();
    xbyte({dev, 1'h0}, 1'h1, r, k0);
    xbyte(a, 1'h1, r, k1);
    xbyte(v, 1'h1, r, k2);
    stop_c();
    nak = k0 | k1 | k2;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] v,
                          output logic nak);
    logic [7:0] r;
    logic k0, k1, k2, k3;
    start_c();
    xbyte({CHGSF_SLAVE_ADDR, 1'h0}, 1'h1, r, k0);
    xbyte(a, 1'h1, r, k1);
    start_c();
    xbyte({CHGSF_SLAVE_ADDR, 1'h1}, 1'h1, r, k2);
    xbyte(8'hFF, 1'h1, v, k3);
    stop_c();
    nak = k0 | k1 | k2;
  endtask

  // Two-byte read; the master acknowledges the first byte to go on
  task automatic read_two(input logic [7:0] a, output logic [15:0] v,
                          output logic nak);
    logic [7:0] r;
    logic k0, k1, k2, k3, k4;
    start_c();
    xbyte({CHGSF_SLAVE_ADDR, 1'h0}, 1'h1, r, k0);
    xbyte(a, 1'h1, r, k1);
    start_c();
    xbyte({CHGSF_SLAVE_ADDR, 1'h1}, 1'h1, r, k2);
    xbyte(8'hFF, 1'h0, v[15:8], k3);
    xbyte(8'hFF, 1'h1, v[7:0], k4);
    stop_c();
    nak = k0 | k1 | k2;
  endtask
endmodule

/* File: testbench/chgsf_regs_tb.sv */
/* Self-checking bench for the charger status and fault register bank.
   Assumes the host model and the bound port checker. */
`timescale 1ns/10ps
module chgsf_regs_tb
  import chgsf_pkg::*;
;
  logic mclk, rstn, ce, chip_disable_pin, sda_out, sda_oe, scl, m_oe;
  logic ship_mode_request, ts_enable, nak;
  logic [3:0] fault_mask, ts_low_ctl;
  logic [7:0] d;
  chgsf_cond_t cond;
  wire logic sda_line;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;

  // Open-drain wire: low whenever either party pulls
  assign sda_line = !(m_oe | sda_oe);

  chgsf_regs chgsf_regs_inst (.mclk(mclk), .rstn(rstn), .ce(ce),
    .scl_in(scl), .sda_in(sda_line), .chip_disable_pin(chip_disable_pin),
    .cond(cond), .sda_out(sda_out), .sda_oe(sda_oe),
    .ship_mode_request(ship_mode_request), .ts_enable(ts_enable),
    .fault_mask(fault_mask), .ts_low_ctl(ts_low_ctl));
  chgsf_host_model chgsf_host_model_inst (.mclk(mclk), .sda_line(sda_line),
    .scl(scl), .sda_oe(m_oe));

  always #20 mclk = ~mclk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    chgsf_host_model_inst.read_reg(a, d, nak);
    check({7'h00, nak}, 8'h00);
    check(d, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    chgsf_host_model_inst.write_reg(CHGSF_SLAVE_ADDR, a, v, nak);
    check({7'h00, nak}, 8'h00);
  endtask

  task automatic t_reset_state();
    check({ship_mode_request, ts_enable, 2'h0, ts_low_ctl},
          8'h48);
    rd_chk(CHGSF_ADDR_STATUS, 8'h01);
    rd_chk(CHGSF_ADDR_FAULT, 8'h00);
    rd_chk(CHGSF_ADDR_TSCTL, 8'h88);
  endtask

  // Every state code, with power management and pin levels varied
  task automatic t_status();
    logic [1:0] s;
    for (int i = 0; i < 4; i++) begin
      s = i[1:0];
      cond.charge_state = s;
      cond.input_dpm_active = s[0];
      chip_disable_pin = s[1];
      wt(6);
      rd_chk(CHGSF_ADDR_STATUS,
             {s, 3'h0, s[0], s[1], 1'h1});
      // Fault state with an empty fault register means input current limit
      if (i == 3) begin
        rd_chk(CHGSF_ADDR_FAULT, 8'h00);
      end
    end
    cond.charge_state = 2'h0;
    cond.input_dpm_active = 1'h0;
    chip_disable_pin = 1'h0;
    wt(6);
  endtask

  task automatic t_status_flags();
    cond.reset_condition = 1'h1;
    cond.timer_expired = 1'h1;
    wt(3);
    cond.reset_condition = 1'h0;
    cond.timer_expired = 1'h0;
    rd_chk(CHGSF_ADDR_STATUS, 8'h19);
    rd_chk(CHGSF_ADDR_STATUS, 8'h09);
    chip_disable_pin = 1'h1;
    wt(6);
    chip_disable_pin = 1'h0;
    wt(6);
    rd_chk(CHGSF_ADDR_STATUS, 8'h01);
  endtask

  // Live flags stay, one-shot flags vanish even while the cause remains
  task automatic t_fault_flags();
    cond.input_overvoltage = 1'h1;
    cond.input_undervoltage = 1'h1;
    cond.battery_undervoltage = 1'h1;
    cond.battery_overcurrent = 1'h1;
    wt(3);
    rd_chk(CHGSF_ADDR_FAULT, 8'hF0);
    rd_chk(CHGSF_ADDR_FAULT, 8'hA0);
    cond.input_overvoltage = 1'h0;
    cond.battery_undervoltage = 1'h0;
    cond.input_undervoltage = 1'h0;
    wt(3);
    cond.input_undervoltage = 1'h1;
    wt(3);
    rd_chk(CHGSF_ADDR_FAULT, 8'h40);
    cond.input_undervoltage = 1'h0;
    cond.battery_overcurrent = 1'h0;
  endtask

  task automatic t_writes();
    logic [15:0] w;
    wr(CHGSF_ADDR_FAULT, 8'hF5);
    check({4'h0, fault_mask}, 8'h05);
    rd_chk(CHGSF_ADDR_FAULT, 8'h05);
    wr(CHGSF_ADDR_STATUS, 8'hFF);
    check({7'h00, ship_mode_request}, 8'h01);
    rd_chk(CHGSF_ADDR_STATUS, 8'h01);
    wr(CHGSF_ADDR_STATUS, 8'h00);
    check({7'h00, ship_mode_request}, 8'h00);
    cond.ts_fault = 2'h2;
    wr(CHGSF_ADDR_TSCTL, 8'h77);
    check({ts_enable, 3'h0, ts_low_ctl}, 8'h07);
    rd_chk(CHGSF_ADDR_TSCTL, 8'h47);
    // Burst read walks the pointer from the fault to the sensing register
    chgsf_host_model_inst.read_two(CHGSF_ADDR_FAULT, w, nak);
    check({7'h00, nak}, 8'h00);
    check(w[15:8], 8'h05);
    check(w[7:0], 8'h47);
  endtask

  task automatic t_refusals();
    rd_chk(8'h03, 8'hFF);
    rd_chk(8'hA5, 8'hFF);
    chgsf_host_model_inst.write_reg(7'h6B, CHGSF_ADDR_FAULT, 8'h0F, nak);
    check({7'h00, nak}, 8'h01);
    check({4'h0, fault_mask}, 8'h05);
    // A set event inside a frozen window must leave no trace
    ce = 1'h0;
    cond.reset_condition = 1'h1;
    wt(5);
    cond.reset_condition = 1'h0;
    ce = 1'h1;
    wt(5);
    rd_chk(CHGSF_ADDR_STATUS, 8'h01);
  endtask

  task final_report;
    $display("errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Whole run is near 62400 cycles; the ceiling leaves a margin
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      $display("wrong value at %0t: run did not finish", $time);
      final_report();
    end
  end

  initial begin
    mclk = 1'h0;
    rstn = 1'h0;
    ce = 1'h1;
    chip_disable_pin = 1'h0;
    cond = '0;
    cond.system_switch_state = 1'h1;
    wt(8);
    rstn = 1'h1;
    wt(3);
    t_reset_state();
    t_status();
    t_status_flags();
    t_fault_flags();
    t_writes();
    t_refusals();
    final_report();
  end
endmodule
